// file: design/kms_pkg.sv
// constants shared by the key matrix scanner
package kms_pkg;
  localparam int unsigned NUM_ROWS           = 8;
  localparam int unsigned NUM_COLS           = 6;
  localparam int unsigned NUM_SELECTS        = 5;
  localparam int unsigned CTL_WIDTH          = 8;
  localparam int unsigned WORD_WIDTH         = 16;
  localparam int unsigned SYNC_STAGES        = 3;
  localparam int unsigned IDX_WIDTH          = 4;
  // control latch field positions
  localparam int unsigned CTL_COL_STROBE_BIT = 0;
  localparam int unsigned CTL_ROW_FORCE_BIT  = 1;
  localparam int unsigned CTL_ROW_STROBE_BIT = 2;
  localparam int unsigned CTL_SELECT_LSB     = 3;
  // key word field positions
  localparam int unsigned WORD_ROW_LSB       = 0;
  localparam int unsigned WORD_COL_LSB       = 8;
  // reset values
  localparam logic [7:0]  CTL_RESET          = 8'h00;
  localparam logic [4:0]  SELECT_N_RESET     = 5'h1F;
  localparam logic [15:0] WORD_RESET         = 16'h00FF;
  localparam logic [3:0]  IDX_RESET          = 4'h0;
endpackage

// file: design/kms_scanner.sv
// key matrix scanner: serial control latch, key capture and key word out
//
// Behaviour
// - serve 48 keys as eight row lines by six column lines.
// - idle capture gives six zero column bits and eight one row bits.
// - interrupt stays asserted while any column line reads high.
// - key interrupt output is active low.
// - control latch takes one serial bit per rising shift clock edge.
// - latch outputs update only on rising edge of the latch input.
// - column strobe rise captures all six column lines.
// - single key column word has one high bit, five low bits.
// - row-read force drives columns low and removes the interrupt.
// - row strobe rise captures row lines 1 to 8.
// - single key row word has one low bit, seven high bits.
// - row bits leave first on the data line, then column bits.
// - host gives 16 key clocks; one word bit leaves per clock.
// - frequency key gives column 2 high and row 2 low.
// - display selects are the inverted latch select bits.
`timescale 1ns/1ps
module kms_scanner #(
  parameter int unsigned NUM_ROWS    = kms_pkg::NUM_ROWS,
  parameter int unsigned NUM_COLS    = kms_pkg::NUM_COLS,
  parameter int unsigned NUM_SELECTS = kms_pkg::NUM_SELECTS
) (
  input  wire logic                   mclk,                  // system clock
  input  wire logic                   rst_n,                 // sync reset
  input  wire logic                   link_clk,              // host clock
  input  wire logic                   ctl_shift_en,          // shift ctl bit
  input  wire logic                   ctl_serial_in,         // ctl data
  input  wire logic                   key_shift_en,          // shift key bit
  input  wire logic                   latch_in,              // latch pin
  input  wire logic [NUM_COLS-1:0]    column_lines,          // column pins
  input  wire logic [NUM_ROWS-1:0]    row_lines,             // row pins
  output logic                        column_capture_strobe, // col strobe
  output logic                        row_capture_strobe,    // row strobe
  output logic                        row_read_force,        // cols low
  output logic [NUM_SELECTS-1:0]      display_select_n,      // selects
  output logic                        key_press_irq_n,       // key irq
  output logic                        key_serial_word        // key data
);

  localparam int unsigned NUM_PINS  = NUM_COLS + NUM_ROWS + 1;
  localparam int unsigned LATCH_PIN = NUM_COLS + NUM_ROWS;
  localparam int unsigned CTL_W     = kms_pkg::CTL_WIDTH;
  localparam int unsigned WORD_W    = kms_pkg::WORD_WIDTH;
  localparam int unsigned IDX_W     = kms_pkg::IDX_WIDTH;
  localparam int unsigned STAGES    = kms_pkg::SYNC_STAGES;

  // link domain
  logic [STAGES-1:0]       lrst_sync_q;
  logic [STAGES-1:0]       lrst_sync_d;
  logic                    lrst_n_q;
  logic                    lrst_n_d;
  logic [CTL_W-1:0]        ctl_shift_q;
  logic [CTL_W-1:0]        ctl_shift_d;
  logic [IDX_W-1:0]        bit_idx_q;
  logic [IDX_W-1:0]        bit_idx_d;
  logic                    serial_q;
  logic                    serial_d;

  // system domain
  logic [NUM_PINS-1:0]     sync1_q;
  logic [NUM_PINS-1:0]     sync2_q;
  logic [NUM_PINS-1:0]     sync3_q;
  logic [NUM_PINS-1:0]     pin_raw;
  logic [NUM_PINS-1:0]     pin_q;
  logic [NUM_PINS-1:0]     pin_d;
  logic                    latch_prev_q;
  logic                    latch_prev_d;
  logic                    latch_rise;
  logic [CTL_W-1:0]        ctl_q;
  logic [CTL_W-1:0]        ctl_d;
  logic                    col_capture;
  logic                    row_capture;
  logic [WORD_W-1:0]       key_word_q;
  logic [WORD_W-1:0]       key_word_d;
  logic [NUM_SELECTS-1:0]  select_n_q;
  logic [NUM_SELECTS-1:0]  select_n_d;
  logic                    col_active;
  logic                    irq_n_q;
  logic                    irq_n_d;

  // reset into the link domain: counts once stages two and three agree
  always_comb
  begin
    lrst_sync_d = {lrst_sync_q[STAGES-2:0], rst_n};
    lrst_n_d    = lrst_n_q;
    if (lrst_sync_q[1] == lrst_sync_q[2])
    begin
      lrst_n_d = lrst_sync_q[2];
    end
  end

  always_ff @(posedge link_clk)
  begin
    lrst_sync_q <= lrst_sync_d;
    lrst_n_q    <= lrst_n_d;
  end

  // control shifter: newest bit enters at the bottom
  always_comb
  begin
    ctl_shift_d = ctl_shift_q;
    if (ctl_shift_en)
    begin
      ctl_shift_d = {ctl_shift_q[CTL_W-2:0], ctl_serial_in};
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_q)
    begin
      ctl_shift_q <= kms_pkg::CTL_RESET;
    end
    else
    begin
      ctl_shift_q <= ctl_shift_d;
    end
  end

  // key word out: one bit per key clock; a control shift restarts the word
  always_comb
  begin
    bit_idx_d = bit_idx_q;
    serial_d  = serial_q;
    if (ctl_shift_en)
    begin
      bit_idx_d = kms_pkg::IDX_RESET;
    end
    else if (key_shift_en)
    begin
      // the word settles long before the host clocks it out
      serial_d  = key_word_q[bit_idx_q];
      bit_idx_d = bit_idx_q + IDX_W'(1);
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_n_q)
    begin
      bit_idx_q <= kms_pkg::IDX_RESET;
      serial_q  <= 1'b0;
    end
    else
    begin
      bit_idx_q <= bit_idx_d;
      serial_q  <= serial_d;
    end
  end

  // the shifter and the key word cross domains as still words: the host
  // stops shifting before it pulses the latch, and reads only after the
  // row capture has settled, so no handshake is needed
  assign pin_raw = {latch_in, row_lines, column_lines};

  // pin inputs: three stages, a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++)
    begin : g_pin
      always_ff @(posedge mclk)
      begin
        sync1_q[gi] <= pin_raw[gi];
        sync2_q[gi] <= sync1_q[gi];
        sync3_q[gi] <= sync2_q[gi];
      end

      always_comb
      begin
        pin_d[gi] = pin_q[gi];
        if (sync2_q[gi] == sync3_q[gi])
        begin
          pin_d[gi] = sync3_q[gi];
        end
      end
    end
  endgenerate

  // filtered pin levels; the raw stages carry no reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_q <= '0;
    end
    else
    begin
      pin_q <= pin_d;
    end
  end

  // edge of the synced latch pin
  always_comb
  begin
    latch_prev_d = pin_d[LATCH_PIN];
    latch_rise   = pin_d[LATCH_PIN] && !latch_prev_q;
  end

  // latch rise takes the shifter, which the host holds still meanwhile
  always_comb
  begin
    ctl_d = ctl_q;
    if (latch_rise)
    begin
      ctl_d = ctl_shift_q;
    end
  end

  // a strobe bit going from low to high captures its lines
  always_comb
  begin
    col_capture = ctl_d[kms_pkg::CTL_COL_STROBE_BIT] &&
                  !ctl_q[kms_pkg::CTL_COL_STROBE_BIT];
    row_capture = ctl_d[kms_pkg::CTL_ROW_STROBE_BIT] &&
                  !ctl_q[kms_pkg::CTL_ROW_STROBE_BIT];
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      latch_prev_q <= 1'b0;
      ctl_q        <= kms_pkg::CTL_RESET;
    end
    else
    begin
      latch_prev_q <= latch_prev_d;
      ctl_q        <= ctl_d;
    end
  end

  // capture: one high bit at the pressed column, one low bit at its row
  genvar bi;
  generate
    for (bi = 0; bi < WORD_W; bi++)
    begin : g_word
      if (bi >= kms_pkg::WORD_COL_LSB &&
          bi <  kms_pkg::WORD_COL_LSB + NUM_COLS)
      begin : g_col
        localparam int unsigned SRC = bi - kms_pkg::WORD_COL_LSB;
        always_comb
        begin
          key_word_d[bi] = key_word_q[bi];
          if (col_capture)
          begin
            key_word_d[bi] = pin_q[SRC];
          end
        end
      end
      else if (bi >= kms_pkg::WORD_ROW_LSB &&
               bi <  kms_pkg::WORD_ROW_LSB + NUM_ROWS)
      begin : g_row
        localparam int unsigned SRC = NUM_COLS + bi - kms_pkg::WORD_ROW_LSB;
        always_comb
        begin
          key_word_d[bi] = key_word_q[bi];
          if (row_capture)
          begin
            key_word_d[bi] = pin_q[SRC];
          end
        end
      end
      else
      begin : g_pad
        // bits past both fields stay zero
        always_comb
        begin
          key_word_d[bi] = 1'b0;
        end
      end
    end
  endgenerate

  // the idle word: columns zero, rows one
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      key_word_q <= kms_pkg::WORD_RESET;
    end
    else
    begin
      key_word_q <= key_word_d;
    end
  end

  // selects follow the new latch value, inverted
  genvar si;
  generate
    for (si = 0; si < NUM_SELECTS; si++)
    begin : g_sel
      always_comb
      begin
        select_n_d[si] = ~ctl_d[kms_pkg::CTL_SELECT_LSB + si];
      end
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      select_n_q <= kms_pkg::SELECT_N_RESET;
    end
    else
    begin
      select_n_q <= select_n_d;
    end
  end

  // any high column asserts; the row-read force removes it
  always_comb
  begin
    col_active = |pin_q[NUM_COLS-1:0];
    irq_n_d    = ~(col_active &&
                   !ctl_q[kms_pkg::CTL_ROW_FORCE_BIT]);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      irq_n_q <= 1'b1;
    end
    else
    begin
      irq_n_q <= irq_n_d;
    end
  end

  // outputs straight from their flops
  assign column_capture_strobe = ctl_q[kms_pkg::CTL_COL_STROBE_BIT];
  assign row_capture_strobe    = ctl_q[kms_pkg::CTL_ROW_STROBE_BIT];
  assign row_read_force        = ctl_q[kms_pkg::CTL_ROW_FORCE_BIT];
  assign display_select_n      = select_n_q;
  assign key_press_irq_n       = irq_n_q;
  assign key_serial_word       = serial_q;

endmodule

// file: test/kms_monitor.sv
// port checker for the key matrix scanner
`timescale 1ns/1ps
module kms_monitor #(
  parameter int unsigned NUM_COLS    = kms_pkg::NUM_COLS,
  parameter int unsigned NUM_SELECTS = kms_pkg::NUM_SELECTS
) (
  input wire logic                   mclk,                  // clock
  input wire logic                   rst_n,                 // reset
  input wire logic                   latch_in,              // latch
  input wire logic [NUM_COLS-1:0]    column_lines,          // columns
  input wire logic                   column_capture_strobe, // strobe
  input wire logic                   row_capture_strobe,    // strobe
  input wire logic                   row_read_force,        // force
  input wire logic [NUM_SELECTS-1:0] display_select_n,      // selects
  input wire logic                   key_press_irq_n        // irq
);
  wire logic [NUM_SELECTS+2:0] outs = {display_select_n, row_capture_strobe,
    row_read_force, column_capture_strobe};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_quiet; (!latch_in)[*8]; endsequence
  sequence s_held; (|column_lines && !row_read_force)[*8]; endsequence
  sequence s_idle; (column_lines == '0)[*8]; endsequence
  a_irq_set: assert property (s_held |-> !key_press_irq_n)
    else $error("irq not low");
  a_irq_idle: assert property (s_idle |-> key_press_irq_n)
    else $error("irq not high");
  a_force_clr: assert property (row_read_force[*7] |-> key_press_irq_n)
    else $error("irq not removed");
  a_quiet_hold: assert property (s_quiet |-> $stable(outs))
    else $error("outputs moved without latch");
  a_rise_hold: assert property ($rose(latch_in) |=> $stable(outs)[*2])
    else $error("outputs moved too early");
  a_rst_vals: assert property ($rose(rst_n) |-> outs == 8'hF8)
    else $error("bad reset outputs");
  a_row_force: assert property
    ($rose(row_capture_strobe) |-> row_read_force)
    else $error("row strobe without force");
  a_col_first: assert property
    ($rose(row_read_force) |-> column_capture_strobe)
    else $error("force before column strobe");
endmodule
bind kms_scanner kms_monitor #(.NUM_COLS(NUM_COLS), .NUM_SELECTS(NUM_SELECTS))
  u_mon (.mclk, .rst_n, .latch_in, .column_lines, .column_capture_strobe,
  .row_capture_strobe, .row_read_force, .display_select_n, .key_press_irq_n);

// file: test/kms_host.sv
// host model: control shift, latch pulse and key word read
`timescale 1ns/1ps
module kms_host (
  input  wire logic lclk,           // free host clock
  output wire logic link_clk,       // gated link clock
  output logic      ctl_shift_en,   // shift control
  output logic      ctl_serial_in,  // control data
  output logic      key_shift_en,   // shift key word
  output logic      latch_in,       // latch pulse
  input  wire logic key_serial_word // key data
);
  logic run = 1'b1;
  assign link_clk = lclk & run;
  initial
  begin
    {ctl_shift_en, ctl_serial_in, key_shift_en, latch_in} = 4'h0;
    // run past reset release so the link side leaves reset
    repeat (40) @(negedge lclk);
    run = 1'b0;
  end
  // key code 01 to 48 from the low row bit and the high column bit
  function automatic int key_code(input logic [15:0] w);
    int code;
    code = 0;
    for (int r = 0; r < 8; r++)
      for (int c = 0; c < 6; c++)
        if (!w[r] && w[8+c]) code = r * 6 + c + 1;
    return code;
  endfunction
  task send(input logic [7:0] b);
    for (int i = 7; i >= -1; i--)
    begin
      @(negedge lclk);
      run = i >= 0;
      ctl_shift_en = i >= 0;
      ctl_serial_in = i >= 0 ? b[i] : ~b[0];
    end
    repeat (2) @(negedge lclk);
    latch_in = 1'b1;
    repeat (8) @(negedge lclk);
    latch_in = 1'b0;
    repeat (8) @(negedge lclk);
  endtask
  task read(output logic [15:0] w);
    for (int i = 0; i <= 16; i++)
    begin
      @(negedge lclk);
      if (i > 0) w[i-1] = key_serial_word;
      run = i < 16;
      key_shift_en = i < 16;
    end
  endtask
endmodule

// file: test/tb.sv
// self-checking bench for the key matrix scanner
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0, lclk = 1'b0, rst_n = 1'b0, pressed = 1'b0;
  logic [5:0] column_lines = 6'h00;
  logic [7:0] row_lines = 8'hFF;
  logic [4:0] display_select_n;
  logic link_clk, ctl_shift_en, ctl_serial_in, key_shift_en, latch_in;
  logic column_capture_strobe, row_capture_strobe, row_read_force;
  logic key_press_irq_n, key_serial_word;
  logic [15:0] w;
  int key_r = 0, key_c = 0, err_count = 0, check_count = 0;
  always #12.5 mclk = ~mclk;
  initial #3.3 forever #7.5 lclk = ~lclk;
  kms_scanner u_dut (.mclk(mclk), .rst_n(rst_n), .link_clk(link_clk),
    .ctl_shift_en(ctl_shift_en), .ctl_serial_in(ctl_serial_in),
    .key_shift_en(key_shift_en), .latch_in(latch_in),
    .column_lines(column_lines), .row_lines(row_lines),
    .row_read_force(row_read_force),
    .column_capture_strobe(column_capture_strobe),
    .row_capture_strobe(row_capture_strobe),
    .display_select_n(display_select_n),
    .key_press_irq_n(key_press_irq_n), .key_serial_word(key_serial_word));
  kms_host u_host (.lclk(lclk), .link_clk(link_clk),
    .ctl_shift_en(ctl_shift_en), .ctl_serial_in(ctl_serial_in),
    .key_shift_en(key_shift_en), .latch_in(latch_in),
    .key_serial_word(key_serial_word));
  // key matrix: force pulls columns and the pressed row low
  always @(negedge mclk)
  begin
    column_lines <= (pressed && !row_read_force) ? 6'h01 << key_c : 6'h00;
    row_lines <= (pressed && row_read_force) ? ~(8'h01 << key_r) : 8'hFF;
  end
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task scan(input logic key, input int r, input int c);
    @(negedge mclk);
    pressed = key;
    key_r = r;
    key_c = c;
    for (int i = 0; i < 20 && key_press_irq_n !== !key; i++) @(negedge mclk);
    chk("irq_n", 16'(!key), 16'(key_press_irq_n));
    u_host.send(8'h01);
    chk("col_strobe", 16'h1, 16'(column_capture_strobe));
    u_host.send(8'h03);
    chk("irq_forced", 16'h1, 16'(key_press_irq_n));
    chk("force", 16'h1, 16'(row_read_force));
    u_host.send(8'h07);
    chk("row_strobe", 16'h1, 16'(row_capture_strobe));
    u_host.read(w);
    chk("word", key ? {2'b00, 6'h01 << c, ~(8'h01 << r)} : 16'h00FF, w);
    if (key) chk("code", 16'(r * 6 + c + 1), 16'(u_host.key_code(w)));
    u_host.send(8'h00);
    @(negedge mclk);
    pressed = 1'b0;
  endtask
  task t_select;
    u_host.send(8'hA8);
    chk("sel_n", 16'h0A, 16'(display_select_n));
    u_host.send(8'h50);
    chk("sel_n", 16'h15, 16'(display_select_n));
  endtask
  initial
  begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (6) @(negedge mclk);
    chk("sel_rst", 16'h1F, 16'(display_select_n));
    scan(1'b0, 0, 0);
    scan(1'b1, 1, 1);
    for (int k = 0; k < 4; k++) scan(1'b1, k[0] ? 7 : 0, k[1] ? 5 : 0);
    t_select;
    results;
  end
  initial
  begin
    #100us;
    err_count++;
    results;
  end
endmodule
